// ===== src/burst_pkg.sv
// Constants shared by the burst trigger controller
package burst_pkg;
  // ************************************************************
  // Register offsets, byte addresses
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] COUNT_ADDR = 8'h04;
  localparam logic [7:0] DELAY_ADDR = 8'h08;
  localparam logic [7:0] PERIOD_ADDR = 8'h0C;
  localparam logic [7:0] PHASE_ADDR = 8'h10;
  localparam logic [7:0] RECLEN_ADDR = 8'h14;
  localparam logic [7:0] TRIG_ADDR = 8'h18;
  localparam logic [7:0] STATUS_ADDR = 8'h1C;
  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_GATED = 1;
  localparam int CTRL_INFINITE = 2;
  localparam int CTRL_SRC_LO = 3;
  localparam int CTRL_SLOPE_FALL = 5;
  localparam int CTRL_TRIG_OUT_EN = 6;
  localparam int CTRL_NOISE = 7;
  localparam int CTRL_FAST = 8;
  localparam int CTRL_GATE_POL_LOW = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ************************************************************
  // Trigger sources
  // ************************************************************
  localparam logic [1:0] SRC_EXTERNAL = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_KEY = 2'h2;
  localparam logic [1:0] SRC_REMOTE = 2'h3;
  // ************************************************************
  // Limits and timing
  // ************************************************************
  localparam logic [19:0] COUNT_MIN = 20'h00001;
  localparam logic [19:0] COUNT_MAX = 20'hF4240; // 1,000,000
  localparam logic [19:0] COUNT_RESET = 20'h00001;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam longint DELAY_MAX_PS = 64'd85_000_000_000_000;
  localparam int DELAY_STEP_PS = 100;
  localparam longint DELAY_MAX_STEPS = DELAY_MAX_PS / DELAY_STEP_PS;
  localparam int STEPS_PER_CYCLE = CLOCK_PERIOD_NS * 1000 / DELAY_STEP_PS;
  localparam longint PERIOD_MIN_MS = 1;
  localparam longint PERIOD_MAX_MS = 500_000;
  localparam longint PERIOD_MIN_CYC = PERIOD_MIN_MS * 1_000_000 / CLOCK_PERIOD_NS;
  localparam longint PERIOD_MAX_CYC = PERIOD_MAX_MS * 1_000_000 / CLOCK_PERIOD_NS;
  localparam int TRIG_OUT_NS = 450;
  localparam int TRIG_OUT_CYC = (TRIG_OUT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS + 1;
  localparam logic [15:0] RECLEN_RESET = 16'h0400;
  // ************************************************************
  // Burst states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10,
    ST_FINISH = 2'b11
  } burst_state_e;
endpackage

// ===== src/phase_map.sv
// Maps a start phase angle onto a waveform record sample index
`timescale 1ns/1ps
module phase_map (
  input wire logic [15:0] phase,
  input wire logic [15:0] rec_len,
  output logic [15:0] start_index
);
  // ************************************************************
  // Proportional mapping
  // ************************************************************
  // Phase is in units of 360/65535 degrees, so full scale lands on the last sample
  logic [31:0] prod;
  always_comb begin
    prod = 32'(phase) * 32'(rec_len - 16'h0001);
    start_index = 16'(prod / 32'h0000_FFFF);
  end
endmodule

// ===== src/burst_trigger_controller.sv
// Burst trigger controller: trigger select, delay, counted and gated bursts
`timescale 1ns/1ps
module burst_trigger_controller (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic TRIG_IN,
  output logic TRIG_OUT,
  output logic TRIG_OE_N,
  input wire logic KEY_TRIG,
  input wire logic CYCLE_END,
  output logic WAVE_ON,
  output logic PHASE_LOAD,
  output logic [15:0] START_INDEX
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] ctrl_reg, ctrl_next;
  logic [19:0] count_reg, count_next;
  logic [39:0] delay_reg, delay_next;
  logic [35:0] period_reg, period_next;
  logic [15:0] phase_reg, phase_next;
  logic [15:0] reclen_reg, reclen_next;
  logic remote_reg, remote_next;
  logic refused_reg, refused_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] start_index;
  logic [15:0] index_reg;

  phase_map u_phase_map (
    .phase(phase_reg),
    .rec_len(reclen_reg),
    .start_index(start_index)
  );

  function automatic logic [35:0] clamp_period(input logic [35:0] v);
    if (64'(v) < burst_pkg::PERIOD_MIN_CYC) begin
      clamp_period = 36'(burst_pkg::PERIOD_MIN_CYC);
    end else if (64'(v) > burst_pkg::PERIOD_MAX_CYC) begin
      clamp_period = 36'(burst_pkg::PERIOD_MAX_CYC);
    end else begin
      clamp_period = v;
    end
  endfunction

  // Burst engine state, declared early for status reads
  burst_pkg::burst_state_e state_reg, state_next;
  logic [19:0] cyc_reg, cyc_next;
  logic refuse_now;

  // ************************************************************
  // Register bus
  // ************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    count_next = count_reg;
    delay_next = delay_reg;
    period_next = period_reg;
    phase_next = phase_reg;
    reclen_next = reclen_reg;
    remote_next = 1'b0;
    refused_next = refused_reg;
    rdata_next = 32'h0000_0000;
    if (WR) begin
      case (ADDR)
        burst_pkg::CTRL_ADDR: ctrl_next = {22'h000000, WDATA[9:0]};
        burst_pkg::COUNT_ADDR: begin
          // Out-of-range counts are clamped rather than refused
          if (WDATA[19:0] < burst_pkg::COUNT_MIN || WDATA[31:20] != 12'h000) begin
            count_next = (WDATA[31:20] != 12'h000) ? burst_pkg::COUNT_MAX : burst_pkg::COUNT_MIN;
          end else if (WDATA[19:0] > burst_pkg::COUNT_MAX) begin
            count_next = burst_pkg::COUNT_MAX;
          end else begin
            count_next = WDATA[19:0];
          end
        end
        burst_pkg::DELAY_ADDR: begin
          // Delay in 100 ps steps
          if (64'(WDATA) > burst_pkg::DELAY_MAX_STEPS) begin
            delay_next = 40'(burst_pkg::DELAY_MAX_STEPS);
          end else begin
            delay_next = 40'(WDATA);
          end
        end
        burst_pkg::PERIOD_ADDR: period_next = clamp_period(36'(WDATA));
        burst_pkg::PHASE_ADDR: phase_next = WDATA[15:0];
        burst_pkg::RECLEN_ADDR: reclen_next = WDATA[15:0];
        burst_pkg::TRIG_ADDR: remote_next = WDATA[0];
        burst_pkg::STATUS_ADDR: if (WDATA[4]) refused_next = 1'b0;
        default: ;
      endcase
    end
    // Set after the clear so a refusal in the clearing cycle is not lost
    if (refuse_now) refused_next = 1'b1;
    if (RD) begin
      case (ADDR)
        burst_pkg::CTRL_ADDR: rdata_next = ctrl_reg;
        burst_pkg::COUNT_ADDR: rdata_next = {12'h000, count_reg};
        burst_pkg::DELAY_ADDR: rdata_next = delay_reg[31:0];
        burst_pkg::PERIOD_ADDR: rdata_next = period_reg[31:0];
        burst_pkg::PHASE_ADDR: rdata_next = {16'h0000, phase_reg};
        burst_pkg::RECLEN_ADDR: rdata_next = {16'h0000, reclen_reg};
        // Cycle count overlaps the low status bits; read it while idle
        burst_pkg::STATUS_ADDR: rdata_next = {11'h000, cyc_reg[19:0], 1'b0} | 
          {27'h0, refused_reg, 1'b0, WAVE_ON, state_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= burst_pkg::CTRL_RESET;
      count_reg <= burst_pkg::COUNT_RESET;
      delay_reg <= 40'h00_0000_0000;
      period_reg <= 36'(burst_pkg::PERIOD_MIN_CYC);
      phase_reg <= 16'h0000;
      reclen_reg <= burst_pkg::RECLEN_RESET;
      remote_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      delay_reg <= delay_next;
      period_reg <= period_next;
      phase_reg <= phase_next;
      reclen_reg <= reclen_next;
      remote_reg <= remote_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Trigger selection
  // ************************************************************
  logic enable, gated, infinite, slope_fall, trig_out_en, noise, fast, gate_low;
  logic [1:0] src;
  logic pin_reg, timer_tick;
  logic [35:0] timer_reg, timer_next;
  logic trig_event, gate_true, ext_edge;
  always_comb begin
    enable = ctrl_reg[burst_pkg::CTRL_ENABLE];
    gated = ctrl_reg[burst_pkg::CTRL_GATED];
    infinite = ctrl_reg[burst_pkg::CTRL_INFINITE];
    src = ctrl_reg[burst_pkg::CTRL_SRC_LO +: 2];
    slope_fall = ctrl_reg[burst_pkg::CTRL_SLOPE_FALL];
    trig_out_en = ctrl_reg[burst_pkg::CTRL_TRIG_OUT_EN] && src != burst_pkg::SRC_EXTERNAL
      && !gated;
    noise = ctrl_reg[burst_pkg::CTRL_NOISE];
    fast = ctrl_reg[burst_pkg::CTRL_FAST];
    gate_low = ctrl_reg[burst_pkg::CTRL_GATE_POL_LOW];
    // Edge chosen by slope select
    ext_edge = slope_fall ? (pin_reg && !TRIG_IN) : (!pin_reg && TRIG_IN);
    gate_true = TRIG_IN ^ gate_low;
    // Reloads while disabled, so the first tick is a full period away
    timer_tick = (timer_reg == 36'h0_0000_0000);
    timer_next = (timer_tick || !enable) ? period_reg - 36'h0_0000_0001 : timer_reg - 36'h0_0000_0001;
    case (src)
      burst_pkg::SRC_EXTERNAL: trig_event = ext_edge && !trig_out_en;
      burst_pkg::SRC_TIMER: trig_event = timer_tick;
      burst_pkg::SRC_KEY: trig_event = KEY_TRIG;
      burst_pkg::SRC_REMOTE: trig_event = remote_reg;
      default: trig_event = 1'b0;
    endcase
  end

  // ************************************************************
  // Burst engine
  // ************************************************************
  logic [39:0] dly_reg, dly_next;
  logic wave_next, load_next;
  // Trigger out length in cycles, rounded up past its minimum width
  logic [9:0] pulse_reg, pulse_next;
  always_comb begin
    state_next = state_reg;
    dly_next = dly_reg;
    cyc_next = cyc_reg;
    wave_next = WAVE_ON;
    load_next = 1'b0;
    pulse_next = (pulse_reg != 10'h000) ? pulse_reg - 10'h001 : 10'h000;
    refuse_now = 1'b0;
    case (state_reg)
      burst_pkg::ST_IDLE: begin
        wave_next = 1'b0;
        if (enable && gated && gate_true) begin
          state_next = burst_pkg::ST_RUN;
          wave_next = 1'b1;
          load_next = 1'b1;
        end else if (enable && !gated && trig_event) begin
          if (fast && !infinite) begin
            refuse_now = 1'b1;
          end else begin
            state_next = burst_pkg::ST_DELAY;
            dly_next = delay_reg;
            if (trig_out_en) pulse_next = 10'(burst_pkg::TRIG_OUT_CYC);
          end
        end
      end
      burst_pkg::ST_DELAY: begin
        // Triggers are not looked at here, so none can overlap
        if (dly_reg < 40'(burst_pkg::STEPS_PER_CYCLE)) begin
          state_next = burst_pkg::ST_RUN;
          wave_next = 1'b1;
          load_next = 1'b1;
          cyc_next = 20'h00000;
        end else begin
          dly_next = dly_reg - 40'(burst_pkg::STEPS_PER_CYCLE);
        end
      end
      burst_pkg::ST_RUN: begin
        if (!enable) begin
          state_next = burst_pkg::ST_IDLE;
          wave_next = 1'b0;
        end else if (gated) begin
          if (!gate_true && noise) begin
            state_next = burst_pkg::ST_IDLE;
            wave_next = 1'b0;
          end else if (!gate_true) begin
            state_next = burst_pkg::ST_FINISH;
          end
        end else if (infinite) begin
          // Infinite bursts re-align on every trigger
          if (trig_event) begin
            state_next = burst_pkg::ST_DELAY;
            dly_next = delay_reg;
            if (trig_out_en) pulse_next = 10'(burst_pkg::TRIG_OUT_CYC);
          end
        end else if (CYCLE_END) begin
          cyc_next = cyc_reg + 20'h00001;
          if (cyc_reg + 20'h00001 >= count_reg) begin
            state_next = burst_pkg::ST_IDLE;
            wave_next = 1'b0;
          end
        end
      end
      burst_pkg::ST_FINISH: begin
        if (CYCLE_END || noise) begin
          state_next = burst_pkg::ST_IDLE;
          wave_next = 1'b0;
        end
      end
      default: state_next = burst_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_reg <= burst_pkg::ST_IDLE;
      dly_reg <= 40'h00_0000_0000;
      cyc_reg <= 20'h00000;
      WAVE_ON <= 1'b0;
      PHASE_LOAD <= 1'b0;
      pulse_reg <= 10'h000;
      TRIG_OUT <= 1'b0;
      TRIG_OE_N <= 1'b1;
      pin_reg <= 1'b0;
      timer_reg <= 36'h0_0000_0000;
      refused_reg <= 1'b0;
      index_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      dly_reg <= dly_next;
      cyc_reg <= cyc_next;
      WAVE_ON <= wave_next;
      PHASE_LOAD <= load_next;
      pulse_reg <= pulse_next;
      TRIG_OUT <= pulse_next != 10'h000;
      TRIG_OE_N <= !trig_out_en;
      pin_reg <= TRIG_IN;
      timer_reg <= timer_next;
      refused_reg <= refused_next;
      index_reg <= start_index;
    end
  end

  always_comb begin
    RDATA = rdata_reg;
    START_INDEX = index_reg;
  end
endmodule

// ===== verif/burst_trigger_controller_asserts.sv
// Port assertions for the burst trigger controller
`timescale 1ns/1ps
module burst_trigger_controller_asserts (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic TRIG_IN,
  input wire logic TRIG_OUT,
  input wire logic CYCLE_END,
  input wire logic WAVE_ON,
  input wire logic PHASE_LOAD,
  input wire logic [15:0] START_INDEX
);
  // ************************************************
  // Trigger out width counter
  // ************************************************
  logic [7:0] high_reg;
  logic [7:0] high_next;
  always_comb begin
    high_next = TRIG_OUT ? high_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      high_reg <= 8'h00;
    end else begin
      high_reg <= high_next;
    end
  end
  // ************************************************
  // Properties
  // ************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_start;
    $rose(WAVE_ON);
  endsequence
  sequence s_pulse;
    $rose(TRIG_OUT);
  endsequence
  a_start_loads: assert property (s_start |-> PHASE_LOAD)
    else $error("start without phase load");
  a_load_runs: assert property (PHASE_LOAD |-> WAVE_ON ##1 !PHASE_LOAD)
    else $error("phase load not one pulse with output on");
  a_load_settled: assert property (PHASE_LOAD |-> $stable(START_INDEX))
    else $error("start index moving at load");
  a_index_held: assert property (WAVE_ON && $past(WAVE_ON) |-> $stable(START_INDEX))
    else $error("start index moved during burst");
  a_pulse_held: assert property (s_pulse |-> TRIG_OUT [*8])
    else $error("trigger out dropped early");
  a_pulse_width: assert property ($fell(TRIG_OUT) |-> high_reg >= 8'h2E)
    else $error("trigger out pulse too short");
  a_stop_at_end: assert property ($fell(WAVE_ON) |->
    $past(CYCLE_END) || $past(TRIG_IN) != $past(TRIG_IN, 4))
    else $error("output stopped away from cycle end");
  a_read_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read answer");
endmodule
bind burst_trigger_controller burst_trigger_controller_asserts asserts_inst (
  .CLOCK(CLOCK), .RESET(RESET), .RD(RD), .RDATA(RDATA), .TRIG_IN(TRIG_IN),
  .TRIG_OUT(TRIG_OUT), .CYCLE_END(CYCLE_END), .WAVE_ON(WAVE_ON),
  .PHASE_LOAD(PHASE_LOAD), .START_INDEX(START_INDEX)
);

// ===== verif/synth_model.sv
// Synthesizer and trigger pin model facing the burst controller
`timescale 1ns/1ps
module synth_model #(parameter int CYC_LEN = 8) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wave_on,
  input wire logic phase_load,
  input wire logic ext_level,
  input wire logic trig_out,
  input wire logic trig_oe_n,
  output logic pin,
  output logic cycle_end,
  output int cycles,
  output int loads
);
  // ************************************************
  // Pin and waveform position
  // ************************************************
  int pos;
  // Outside source stands off while the device drives the pin
  assign pin = trig_oe_n ? ext_level : trig_out;
  // Resting output gives no cycle ends
  // A restart takes the place of a cycle end
  assign cycle_end = wave_on && !phase_load && pos == CYC_LEN - 1;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pos <= 0;
      cycles <= 0;
      loads <= 0;
    end else if (phase_load) begin
      pos <= 0;
      loads <= loads + 1;
    end else if (wave_on) begin
      pos <= cycle_end ? 0 : pos + 1;
      cycles <= cycles + (cycle_end ? 1 : 0);
    end
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the burst trigger controller
`timescale 1ns/1ps
module tb;
  // ************************************************
  // Bench
  // ************************************************
  localparam int CYC = 8;
  logic clock;
  logic reset;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic pin;
  logic trig_out;
  logic trig_oe_n;
  logic key;
  logic cycle_end;
  logic wave_on;
  logic phase_load;
  logic [15:0] start_index;
  logic ext;
  logic [31:0] got;
  int cycles;
  int loads;
  int fail_count;
  int checked;
  int lat;
  int t0;
  int tick;
  burst_trigger_controller burst_trigger_controller_inst (
    .CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TRIG_IN(pin), .TRIG_OUT(trig_out), .TRIG_OE_N(trig_oe_n),
    .KEY_TRIG(key), .CYCLE_END(cycle_end), .WAVE_ON(wave_on), .PHASE_LOAD(phase_load),
    .START_INDEX(start_index));
  synth_model #(.CYC_LEN(CYC)) synth_model_inst (
    .clock(clock), .reset(reset), .wave_on(wave_on), .phase_load(phase_load),
    .ext_level(ext), .trig_out(trig_out), .trig_oe_n(trig_oe_n), .pin(pin),
    .cycle_end(cycle_end), .cycles(cycles), .loads(loads));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    tick++;
    if (tick == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Every access leaves one idle cycle so a strobe never changes twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
    got = rdata;
  endtask
  task automatic fire(input logic [1:0] src);
    if (src == burst_pkg::SRC_REMOTE) begin
      bus(1'b1, burst_pkg::TRIG_ADDR, 32'h1);
    end else if (src == burst_pkg::SRC_EXTERNAL) begin
      ext <= !ext;
      @(posedge clock);
    end else begin
      key <= 1'b1;
      @(posedge clock);
      key <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic wait_on(input logic lv, output int n);
    n = 0;
    while (wave_on !== lv && n < 400) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask
  task automatic burst(input logic [31:0] ctrl, input int n);
    int c0;
    int l0;
    int t;
    bus(1'b1, burst_pkg::COUNT_ADDR, n);
    bus(1'b1, burst_pkg::CTRL_ADDR, ctrl);
    ext <= ctrl[5];
    @(posedge clock);
    chk("pin enable", {31'h0, !ctrl[6]}, {31'h0, trig_oe_n});
    c0 = cycles;
    l0 = loads;
    fire(ctrl[4:3]);
    wait_on(1'b1, lat);
    chk("trigger out", {31'h0, ctrl[6]}, {31'h0, trig_out & ctrl[6]});
    fire(ctrl[4:3]);
    wait_on(1'b0, t);
    repeat (20) @(posedge clock);
    chk("cycles", n, cycles - c0);
    chk("starts", 32'h1, loads - l0);
  endtask
  task automatic gate(input logic slow);
    int t;
    ext <= 1'b1;
    wait_on(1'b1, t);
    chk("gate on", 32'h1, {31'h0, wave_on});
    while (cycle_end !== 1'b1) begin
      @(posedge clock);
    end
    ext <= 1'b0;
    repeat (3) @(posedge clock);
    chk("gate off", {31'h0, slow}, {31'h0, wave_on});
    wait_on(1'b0, t);
    chk("rest", 32'h1, {31'h0, t <= CYC});
  endtask
  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    key = 1'b0;
    ext = 1'b0;
    do_reset();
    bus(1'b0, burst_pkg::RECLEN_ADDR, 32'h0);
    chk("length", {16'h0, burst_pkg::RECLEN_RESET}, got);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, got);
    bus(1'b1, burst_pkg::COUNT_ADDR, 32'h0);
    bus(1'b0, burst_pkg::COUNT_ADDR, 32'h0);
    chk("count", {12'h0, burst_pkg::COUNT_MIN}, got);
    bus(1'b1, burst_pkg::PERIOD_ADDR, 32'h5);
    bus(1'b0, burst_pkg::PERIOD_ADDR, 32'h0);
    chk("period", 32'h000186A0, got);
    bus(1'b1, burst_pkg::PHASE_ADDR, 32'hFFFF);
    repeat (3) @(posedge clock);
    chk("last sample", {16'h0, burst_pkg::RECLEN_RESET - 16'h1}, {16'h0, start_index});
    bus(1'b1, burst_pkg::PHASE_ADDR, 32'h0);
    repeat (3) @(posedge clock);
    chk("first sample", 32'h0, {16'h0, start_index});
    burst(32'h11, 1);
    t0 = lat;
    burst(32'h19, 3);
    burst(32'h01, 2);
    burst(32'h21, 2);
    burst(32'h51, 1);
    bus(1'b1, burst_pkg::DELAY_ADDR, 32'h3E8);
    burst(32'h11, 3);
    chk("delay", 32'hA, lat - t0);
    do_reset();
    bus(1'b1, burst_pkg::COUNT_ADDR, 32'h3);
    bus(1'b1, burst_pkg::CTRL_ADDR, 32'h111);
    fire(burst_pkg::SRC_KEY);
    repeat (20) @(posedge clock);
    chk("refused", 32'h0, {31'h0, wave_on});
    bus(1'b0, burst_pkg::STATUS_ADDR, 32'h0);
    chk("refused flag", 32'h1, {31'h0, got[4]});
    bus(1'b1, burst_pkg::CTRL_ADDR, 32'h115);
    fire(burst_pkg::SRC_KEY);
    wait_on(1'b1, lat);
    repeat (CYC * 6) @(posedge clock);
    chk("endless", 32'h1, {31'h0, wave_on});
    t0 = loads;
    fire(burst_pkg::SRC_KEY);
    repeat (6) @(posedge clock);
    chk("restart", 32'h1, loads - t0);
    chk("still on", 32'h1, {31'h0, wave_on});
    do_reset();
    chk("after reset", 32'h0, {31'h0, wave_on});
    bus(1'b1, burst_pkg::CTRL_ADDR, 32'h03);
    gate(1'b1);
    bus(1'b1, burst_pkg::CTRL_ADDR, 32'h83);
    gate(1'b0);
    end_of_test();
  end
endmodule
